// ===== rtl/ssau_pkg.sv
package ssau_pkg;

  localparam int unsigned WORD_W = 32;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned HALF_LANES = 2;
  localparam int unsigned BYTE_LANES = 4;
  localparam int unsigned REG_IDX_W = 4;
  localparam int unsigned FLAG_W = 4;

  // Register indices the instruction source must never select
  localparam logic [3:0] REG_SP = 4'hD;
  localparam logic [3:0] REG_PC = 4'hF;

  // Positions inside the flags vector
  localparam int unsigned FLAG_N_BIT = 3;
  localparam int unsigned FLAG_Z_BIT = 2;
  localparam int unsigned FLAG_C_BIT = 1;
  localparam int unsigned FLAG_V_BIT = 0;

  // Reset values
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [3:0] FLAG_RST = 4'h0;
  localparam logic [3:0] REG_RST = 4'h0;

  typedef enum logic [3:0] {
    signed_dual_half_add            = 4'h0,
    signed_quad_byte_add            = 4'h1,
    signed_halving_dual_half_add    = 4'h2,
    signed_halving_quad_byte_add    = 4'h3,
    signed_halving_add_sub_exchange = 4'h4,
    signed_halving_sub_add_exchange = 4'h5,
    signed_halving_dual_half_sub    = 4'h6,
    signed_halving_quad_byte_sub    = 4'h7,
    signed_dual_half_sub            = 4'h8,
    signed_quad_byte_sub            = 4'h9,
    signed_add_sub_exchange         = 4'hA,
    signed_sub_add_exchange         = 4'hB
  } ssau_op_type;

  typedef enum logic [3:0] {
    cond_eq = 4'h0, cond_ne = 4'h1, cond_cs = 4'h2, cond_cc = 4'h3,
    cond_mi = 4'h4, cond_pl = 4'h5, cond_vs = 4'h6, cond_vc = 4'h7,
    cond_hi = 4'h8, cond_ls = 4'h9, cond_ge = 4'hA, cond_lt = 4'hB,
    cond_gt = 4'hC, cond_le = 4'hD, cond_al = 4'hE, cond_nv = 4'hF
  } ssau_cond_type;

  typedef struct packed {
    logic valid;
    ssau_op_type op;
    ssau_cond_type cond;
    logic [3:0] flags;
    logic dest_given;
    logic [3:0] dest_reg;
    logic [3:0] first_operand_reg;
    logic [3:0] second_operand_reg;
    logic [31:0] first_operand;
    logic [31:0] second_operand;
  } ssau_req_type;

  typedef struct packed {
    logic valid;
    logic wr_en;
    logic skipped;
    logic illegal;
    logic [3:0] wr_reg;
    logic [31:0] data;
  } ssau_res_type;

  typedef struct packed {
    logic quad;
    logic halve;
    logic exchange;
    logic [1:0] half_sub;
    logic byte_sub;
  } ssau_ctl_type;

endpackage

// ===== rtl/ssau_lane.sv
`timescale 1ns/10ps
`default_nettype none

module ssau_lane #(
  parameter int unsigned W = 8
) (
  input wire logic [W-1:0] a_i,
  input wire logic [W-1:0] b_i,
  input wire logic sub_i,
  input wire logic halve_i,
  output logic [W-1:0] y_o
);

  logic [W:0] wide;

  // One guard bit keeps the halved value exact for every input pair
  always_comb begin
    if (sub_i) begin
      wide = {a_i[W-1], a_i} - {b_i[W-1], b_i};
    end else begin
      wide = {a_i[W-1], a_i} + {b_i[W-1], b_i};
    end
  end

  // Arithmetic halving drops the low bit of the widened result
  always_comb begin
    if (halve_i) begin
      y_o = wide[W:1];
    end else begin
      y_o = wide[W-1:0];
    end
  end

endmodule

`default_nettype wire

// ===== rtl/ssau_unit.sv
// Contract
// - Two signed halfword sums, no cross-lane carry
// - Four independent signed byte sums
// - Non-halving add results stay in their lanes
// - Halving variants shift each lane right once
// - Halving halfword add writes matching halfwords
// - Halving byte add writes matching bytes
// - Halving add-sub exchange: upper gets halved sum
// - Halving add-sub exchange: lower gets halved difference
// - Halving sub-add exchange: upper gets halved difference
// - Halving sub-add exchange: lower gets halved sum
// - Halving halfword subtract, first minus second
// - Halving byte subtract, four signed bytes
// - Two signed halfword differences, matching lanes
// - Four signed byte differences, matching lanes
// - Condition flags are never changed
// - Missing destination writes first operand register
// - Write back only when condition holds
// - Add-sub exchange: upper gets crossed sum
// - Non-halving exchange ops: lower gets crossed difference
`timescale 1ns/10ps
`default_nettype none

module ssau_unit
  import ssau_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire ssau_req_type req_i,
  output ssau_res_type res_o,
  output logic [3:0] flags_o,
  output logic illegal_o
);

  // Stage one: captured request and its decoded controls
  ssau_req_type s1_q;
  ssau_ctl_type s1_ctl_q;
  logic s1_pass_q;
  logic s1_illegal_q;
  logic [3:0] s1_wr_reg_q;

  ssau_ctl_type ctl_d;
  logic pass_d;
  logic illegal_d;
  logic [3:0] wr_reg_d;

  // Older write kept for bypass; the register file may lag one cycle
  logic hist_en_q;
  logic [3:0] hist_reg_q;
  logic [31:0] hist_data_q;

  logic [31:0] opa;
  logic [31:0] opb;
  logic [31:0] half_y;
  logic [31:0] byte_y;
  logic [31:0] result;

  ssau_res_type res_d;

  function automatic ssau_ctl_type decode_op(input ssau_op_type op);
    ssau_ctl_type c;
    c.quad = 1'b0;
    c.halve = 1'b0;
    c.exchange = 1'b0;
    c.half_sub = 2'b00;
    c.byte_sub = 1'b0;
    case (op)
      signed_dual_half_add: begin
        c.half_sub = 2'b00;
      end
      signed_quad_byte_add: begin
        c.quad = 1'b1;
      end
      signed_halving_dual_half_add: begin
        c.halve = 1'b1;
      end
      signed_halving_quad_byte_add: begin
        c.quad = 1'b1;
        c.halve = 1'b1;
      end
      signed_halving_add_sub_exchange: begin
        c.halve = 1'b1;
        c.exchange = 1'b1;
        c.half_sub = 2'b01;
      end
      signed_halving_sub_add_exchange: begin
        c.halve = 1'b1;
        c.exchange = 1'b1;
        c.half_sub = 2'b10;
      end
      signed_halving_dual_half_sub: begin
        c.halve = 1'b1;
        c.half_sub = 2'b11;
      end
      signed_halving_quad_byte_sub: begin
        c.quad = 1'b1;
        c.halve = 1'b1;
        c.byte_sub = 1'b1;
      end
      signed_dual_half_sub: begin
        c.half_sub = 2'b11;
      end
      signed_quad_byte_sub: begin
        c.quad = 1'b1;
        c.byte_sub = 1'b1;
      end
      signed_add_sub_exchange: begin
        c.exchange = 1'b1;
        c.half_sub = 2'b01;
      end
      signed_sub_add_exchange: begin
        // Difference lands in the lower half, as the worked example shows
        c.exchange = 1'b1;
        c.half_sub = 2'b01;
      end
      default: begin
        c.quad = 1'b0;
      end
    endcase
    return c;
  endfunction

  function automatic logic cond_holds(input ssau_cond_type cond,
                                      input logic [3:0] flags);
    logic n;
    logic z;
    logic c;
    logic v;
    logic ok;
    n = flags[FLAG_N_BIT];
    z = flags[FLAG_Z_BIT];
    c = flags[FLAG_C_BIT];
    v = flags[FLAG_V_BIT];
    ok = 1'b0;
    case (cond)
      cond_eq: begin
        ok = z;
      end
      cond_ne: begin
        ok = ~z;
      end
      cond_cs: begin
        ok = c;
      end
      cond_cc: begin
        ok = ~c;
      end
      cond_mi: begin
        ok = n;
      end
      cond_pl: begin
        ok = ~n;
      end
      cond_vs: begin
        ok = v;
      end
      cond_vc: begin
        ok = ~v;
      end
      cond_hi: begin
        ok = c & ~z;
      end
      cond_ls: begin
        ok = ~c | z;
      end
      cond_ge: begin
        ok = (n == v);
      end
      cond_lt: begin
        ok = (n != v);
      end
      cond_gt: begin
        ok = ~z & (n == v);
      end
      cond_le: begin
        ok = z | (n != v);
      end
      cond_al: begin
        ok = 1'b1;
      end
      // The spare code also passes, so no encoding can silently drop a write
      cond_nv: begin
        ok = 1'b1;
      end
      default: begin
        ok = 1'b1;
      end
    endcase
    return ok;
  endfunction

  function automatic logic bad_reg(input logic [3:0] idx);
    return (idx == REG_SP) || (idx == REG_PC);
  endfunction

  // Decode, condition check and destination choice at issue
  always_comb begin
    ctl_d = decode_op(req_i.op);
    pass_d = cond_holds(req_i.cond, req_i.flags);
    if (req_i.dest_given) begin
      wr_reg_d = req_i.dest_reg;
    end else begin
      wr_reg_d = req_i.first_operand_reg;
    end
    // A forbidden index is flagged and its write dropped, not executed
    illegal_d = bad_reg(wr_reg_d)
              | bad_reg(req_i.first_operand_reg)
              | bad_reg(req_i.second_operand_reg);
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1_q <= '0;
    end else begin
      s1_q <= req_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1_ctl_q <= '0;
      s1_pass_q <= 1'b0;
      s1_illegal_q <= 1'b0;
      s1_wr_reg_q <= REG_RST;
    end else begin
      s1_ctl_q <= ctl_d;
      s1_pass_q <= pass_d;
      s1_illegal_q <= illegal_d;
      s1_wr_reg_q <= wr_reg_d;
    end
  end

  // Operand bypass: newest write wins over the older one
  always_comb begin
    opa = s1_q.first_operand;
    if (res_o.wr_en && res_o.wr_reg == s1_q.first_operand_reg) begin
      opa = res_o.data;
    end else if (hist_en_q && hist_reg_q == s1_q.first_operand_reg) begin
      opa = hist_data_q;
    end
  end

  always_comb begin
    opb = s1_q.second_operand;
    if (res_o.wr_en && res_o.wr_reg == s1_q.second_operand_reg) begin
      opb = res_o.data;
    end else if (hist_en_q && hist_reg_q == s1_q.second_operand_reg) begin
      opb = hist_data_q;
    end
  end

  // Byte lanes: each sees only its own byte, so no carry crosses
  for (genvar i = 0; i < BYTE_LANES; i++) begin : g_byte
    ssau_lane #(
      .W(BYTE_W)
    ) u_lane (
      .a_i(opa[i*BYTE_W +: BYTE_W]),
      .b_i(opb[i*BYTE_W +: BYTE_W]),
      .sub_i(s1_ctl_q.byte_sub),
      .halve_i(s1_ctl_q.halve),
      .y_o(byte_y[i*BYTE_W +: BYTE_W])
    );
  end

  // Halfword lanes: exchange feeds each lane the opposite second half
  for (genvar i = 0; i < HALF_LANES; i++) begin : g_half
    logic [15:0] b_sel;
    always_comb begin
      if (s1_ctl_q.exchange) begin
        b_sel = opb[(1-i)*HALF_W +: HALF_W];
      end else begin
        b_sel = opb[i*HALF_W +: HALF_W];
      end
    end
    ssau_lane #(
      .W(HALF_W)
    ) u_lane (
      .a_i(opa[i*HALF_W +: HALF_W]),
      .b_i(b_sel),
      .sub_i(s1_ctl_q.half_sub[i]),
      .halve_i(s1_ctl_q.halve),
      .y_o(half_y[i*HALF_W +: HALF_W])
    );
  end

  // Lane results keep the lane position they were taken from
  always_comb begin
    if (s1_ctl_q.quad) begin
      result = byte_y;
    end else begin
      result = half_y;
    end
  end

  always_comb begin
    res_d.valid = s1_q.valid;
    res_d.illegal = s1_q.valid & s1_illegal_q;
    res_d.skipped = s1_q.valid & ~s1_illegal_q & ~s1_pass_q;
    res_d.wr_en = s1_q.valid & s1_pass_q & ~s1_illegal_q;
    res_d.wr_reg = s1_wr_reg_q;
    res_d.data = result;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      res_o <= '0;
    end else begin
      res_o <= res_d;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hist_en_q <= 1'b0;
      hist_reg_q <= REG_RST;
      hist_data_q <= DATA_RST;
    end else begin
      hist_en_q <= res_o.wr_en;
      hist_reg_q <= res_o.wr_reg;
      hist_data_q <= res_o.data;
    end
  end

  // Flags pass through untouched; this unit has no path to alter them
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flags_o <= FLAG_RST;
    end else begin
      flags_o <= s1_q.flags;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      illegal_o <= 1'b0;
    end else begin
      illegal_o <= s1_q.valid & s1_illegal_q;
    end
  end

endmodule

`default_nettype wire

// ===== test/ssau_unit_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module ssau_unit_monitor
  import ssau_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire ssau_req_type req_i,
  input wire ssau_res_type res_o,
  input wire logic [3:0] flags_o,
  input wire logic illegal_o
);
  // Conservative: index 14 is legal but left out to keep this short
  wire logic ok_w = req_i.valid && req_i.dest_reg < REG_SP &&
    req_i.first_operand_reg < REG_SP && req_i.second_operand_reg < REG_SP;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  a_result_latency: assert property (
    req_i.valid |-> ##2 res_o.valid) else $error("result missing");
  a_no_spurious: assert property (
    res_o.valid |-> $past(req_i.valid, 2))
    else $error("result without request");
  a_flags_kept: assert property (req_i.valid |-> ##2
    flags_o == $past(req_i.flags, 2)) else $error("flags changed");
  a_illegal_mirror: assert property (
    illegal_o == res_o.illegal) else $error("illegal outputs differ");
  a_forbidden_index: assert property (req_i.valid &&
    req_i.second_operand_reg == REG_PC |-> ##2
    res_o.illegal && !res_o.wr_en) else $error("forbidden index written");
  a_always_writes: assert property (
    ok_w && req_i.cond == cond_al |->
    ##2 res_o.wr_en) else $error("unconditional op not written");
  a_eq_skips: assert property (ok_w && req_i.cond == cond_eq &&
    !req_i.flags[FLAG_Z_BIT] |-> ##2 res_o.skipped && !res_o.wr_en)
    else $error("failed condition written");
  a_default_dest: assert property (
    ok_w && !req_i.dest_given |-> ##2
    !res_o.wr_en || res_o.wr_reg == $past(req_i.first_operand_reg, 2))
    else $error("default destination wrong");
  a_given_dest: assert property (
    ok_w && req_i.dest_given |-> ##2
    !res_o.wr_en || res_o.wr_reg == $past(req_i.dest_reg, 2))
    else $error("destination wrong");
endmodule
`default_nettype wire

// ===== test/ssau_regfile_model.sv
`timescale 1ns/10ps
`default_nettype none
module ssau_regfile_model
  import ssau_pkg::*;
#(
  parameter logic [31:0] A_INIT = 32'h0,
  parameter logic [31:0] B_INIT = 32'h0
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire ssau_res_type res_i,
  input wire logic [3:0] rd_a_i,
  input wire logic [3:0] rd_b_i,
  output logic [31:0] a_o,
  output logic [31:0] b_o
);
  logic [31:0] rf_q [16];
  // Plain reads; the unit itself refuses indices 13 and 15
  assign a_o = rf_q[rd_a_i];
  assign b_o = rf_q[rd_b_i];
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 16; i++) begin
        rf_q[i] <= (i == 3) ? B_INIT : A_INIT;
      end
    end else if (res_i.valid && res_i.wr_en) begin
      rf_q[res_i.wr_reg] <= res_i.data;
    end
  end
endmodule
`default_nettype wire

// ===== test/ssau_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module ssau_unit_tb
  import ssau_pkg::*;
();
  typedef struct packed {logic [3:0] op; logic [31:0] exp;} ssau_row_type;
  localparam logic [31:0] A_VAL = 32'h7F7F_8080;
  localparam logic [31:0] B_VAL = 32'h01FF_8001;
  localparam logic [31:0] COND_OK = 32'hE655_D6AA;
  localparam ssau_row_type ROWS [12] = '{
    '{4'h0, 32'h817E_0081},
    '{4'h1, 32'h807E_0081},
    '{4'h2, 32'h40BF_8040},
    '{4'h3, 32'h403F_80C0},
    '{4'h4, 32'hFFC0_BF40},
    '{4'h5, 32'h7FBF_C13F},
    '{4'h6, 32'h3EC0_003F},
    '{4'h7, 32'h3F40_00BF},
    '{4'h8, 32'h7D80_007F},
    '{4'h9, 32'h7E80_007F},
    '{4'hA, 32'hFF80_7E81},
    '{4'hB, 32'hFF80_7E81}
  };
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  ssau_req_type rq = '0;
  ssau_req_type req_w;
  ssau_res_type res_w;
  ssau_res_type got;
  logic [3:0] flags_w;
  logic illegal_w;
  logic [31:0] a_w;
  logic [31:0] b_w;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  // Operand data always comes from the model, as read at issue
  assign req_w = {rq[89:64], a_w, b_w};
  ssau_unit dut_u (.core_clk_i(core_clk), .sys_rst_i(sys_rst),
    .req_i(req_w), .res_o(res_w), .flags_o(flags_w), .illegal_o(illegal_w));
  ssau_regfile_model #(.A_INIT(A_VAL), .B_INIT(B_VAL)) rf_u (
    .core_clk_i(core_clk), .sys_rst_i(sys_rst), .res_i(res_w),
    .rd_a_i(rq.first_operand_reg), .rd_b_i(rq.second_operand_reg),
    .a_o(a_w), .b_o(b_w));
  initial begin
    forever begin
      #5 core_clk = ~core_clk;
    end
  end
  task automatic wrap_up();
    $display("compared %0d, failed %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      failures++;
      wrap_up();
    end
  end
  // One request, then wait for its result; the gap keeps bypass legal
  task automatic run(input ssau_op_type op, input logic [3:0] cnd, fl, d, f,
    s, input logic dg);
    int n;
    n = 0;
    @(posedge core_clk);
    #1;
    rq = '{1'b1, op, ssau_cond_type'(cnd), fl, dg, d, f, s, 32'h0, 32'h0};
    @(posedge core_clk);
    #1;
    rq.valid = 1'b0;
    while (res_w.valid !== 1'b1 && n < 4) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    got = res_w;
    `CHK(flags_w, fl)
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    `CHK({res_w, flags_w, illegal_w}, '0)
    #1 sys_rst = 1'b0;
    $display("reset done");
    foreach (ROWS[i]) begin
      run(ssau_op_type'(ROWS[i].op), 4'hE, 4'(i), 4'h1, 4'h2, 4'h3, 1'b1);
      `CHK(got.data, ROWS[i].exp)
      `CHK({got.valid, got.wr_en, got.wr_reg}, 6'h31)
    end
    $display("rows done");
    for (int k = 0; k < 32; k++) begin
      run(signed_dual_half_add, k[3:0], k[4] ? 4'hF : 4'h0, 4'h1, 4'h2,
        4'h3, 1'b1);
      `CHK({got.wr_en, got.skipped}, {COND_OK[k], ~COND_OK[k]})
    end
    $display("conditions done");
    for (int k = 0; k < 3; k++) begin
      run(signed_dual_half_add, 4'hE, 4'h0, k == 0 ? REG_SP : 4'h1,
        k == 1 ? REG_PC : 4'h2, k == 2 ? REG_PC : 4'h3, 1'b1);
      `CHK({got.illegal, illegal_w, got.wr_en}, 3'b110)
    end
    $display("illegal done");
    run(signed_dual_half_add, 4'hE, 4'h0, 4'h0, 4'h2, 4'h3, 1'b0);
    `CHK({got.wr_reg, got.data}, 36'h2_817E_0081)
    run(signed_dual_half_add, 4'hE, 4'h0, 4'h0, 4'h2, 4'h3, 1'b0);
    `CHK({got.wr_reg, got.data}, 36'h2_837D_8082)
    run(signed_dual_half_add, 4'h0, 4'h0, 4'h0, 4'h2, 4'h3, 1'b0);
    `CHK(got.skipped, 1'b1)
    run(signed_dual_half_add, 4'hE, 4'h0, 4'h0, 4'h2, 4'h3, 1'b0);
    `CHK(got.data, 32'h857C_0083)
    $display("writeback done");
    @(posedge core_clk);
    #1 sys_rst = 1'b1;
    #2;
    `CHK({res_w, flags_w, illegal_w}, '0)
    $display("second reset done");
    wrap_up();
  end
endmodule
bind ssau_unit ssau_unit_monitor mon_u (.core_clk_i(core_clk_i),
  .sys_rst_i(sys_rst_i), .req_i(req_i), .res_o(res_o), .flags_o(flags_o),
  .illegal_o(illegal_o));
`default_nettype wire
